// >>> rtl/cfg_access_if.sv
// interface: register access strobes between serial port and register bank
interface cfg_access_if;
  import dac_cfg_pkg::*;
  logic wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : cfg_access_if

// >>> rtl/cfg_serial_port.sv
// module: serial configuration port, oversampled on the core clock
module cfg_serial_port (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  cfg_access_if.port acc
);
  import dac_cfg_pkg::*;

  // ****************************************
  // pin synchronisers: index 2 chip select, 1 clock, 0 data
  // ****************************************
  logic [2:0] pins;
  logic [2:0] stab_q;
  logic [2:0] prev_q;
  assign pins = {csb_n, sclk, sdio_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic [2:0] sync_q;
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync_q <= {3{PIN_RST[gi]}};
          stab_q[gi] <= PIN_RST[gi];
          prev_q[gi] <= PIN_RST[gi];
        end else begin
          sync_q <= {sync_q[1:0], pins[gi]};
          // a change counts once the second and third stage agree
          if (sync_q[1] == sync_q[2]) begin
            stab_q[gi] <= sync_q[2];
          end
          prev_q[gi] <= stab_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // frame decode
  // ****************************************
  logic active;
  logic sclk_rise;
  logic sclk_fall;
  logic is_read;
  logic in_data;
  logic [4:0] cnt_q;
  logic [INSTR_BITS-1:0] instr_q;
  logic [DATA_W-1:0] dat_q;
  logic [DATA_W-1:0] tx_q;
  logic wr_stb_q;
  logic sdo_q;
  logic oe_q;

  assign active = ~stab_q[2];
  assign sclk_rise = stab_q[1] & ~prev_q[1];
  assign sclk_fall = ~stab_q[1] & prev_q[1];
  assign is_read = instr_q[RW_BIT];
  assign in_data = (cnt_q >= 5'(INSTR_BITS)) && (cnt_q < 5'(FRAME_BITS));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
      instr_q <= 16'h0000;
      dat_q <= 8'h00;
      wr_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (!active) begin
        cnt_q <= 5'h00;
      end else if (sclk_rise && cnt_q != 5'(FRAME_BITS)) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q < 5'(INSTR_BITS)) begin
          instr_q <= {instr_q[INSTR_BITS-2:0], stab_q[0]};
        end else begin
          dat_q <= {dat_q[DATA_W-2:0], stab_q[0]};
        end
        // write lands on the last data bit; extra clocks are ignored
        wr_stb_q <= (cnt_q == 5'(FRAME_BITS - 1)) & ~is_read;
      end
    end
  end

  // read data leaves on falling edges so the host samples it on rising ones
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!active) begin
      oe_q <= 1'b0;
    end else if (sclk_fall && in_data && is_read) begin
      oe_q <= 1'b1;
      if (cnt_q == 5'(INSTR_BITS)) begin
        sdo_q <= acc.rdata[DATA_W-1];
        tx_q <= {acc.rdata[DATA_W-2:0], 1'b0};
      end else begin
        sdo_q <= tx_q[DATA_W-1];
        tx_q <= {tx_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  assign acc.wr_stb = wr_stb_q;
  assign acc.addr = instr_q[ADDR_W-1:0];
  assign acc.wdata = dat_q;
  assign sdio_o = sdo_q;
  assign sdio_oe = oe_q;

endmodule : cfg_serial_port

// >>> rtl/dac_cfg_pkg.sv
// package: register map, field positions, reset values and frame sizes of the config block
package dac_cfg_pkg;

  // ****************************************
  // serial frame layout
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int INSTR_BITS = 16;
  localparam int FRAME_BITS = 24;
  localparam int RW_BIT = 15;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] CLKRX_OFS = 13'h0032;
  localparam logic [ADDR_W-1:0] DLYCTL_OFS = 13'h0033;
  localparam logic [ADDR_W-1:0] BIAS_OFS = 13'h0036;

  // ****************************************
  // clock_receiver_control fields
  // ****************************************
  localparam int CLKRX_EN_BIT = 7;
  localparam int CLKRX_RSVD_BIT = 6;
  localparam int CLKRX_POS_PIN_LEVEL_POLARITY_BIT = 5;
  localparam int CLKRX_PADJ_HI = 4;
  localparam int CLKRX_PADJ_LO = 1;
  localparam int CLKRX_NEG_PIN_LEVEL_POLARITY_BIT = 0;
  localparam logic [DATA_W-1:0] CLKRX_RST = 8'h1E;

  // ****************************************
  // delay_lock_control fields
  // ****************************************
  localparam int DLY_GATE_BIT = 7;
  localparam int DLY_SLOPE_BIT = 6;
  localparam int DLY_MODE_HI = 5;
  localparam int DLY_MODE_LO = 4;
  localparam int DLY_CAPT_BIT = 3;
  localparam int DLY_GAIN_HI = 2;
  localparam int DLY_GAIN_LO = 1;
  localparam int DLY_EN_BIT = 0;
  localparam logic [1:0] CODE_INVALID = 2'h3;
  localparam logic [DATA_W-1:0] DLYCTL_RST = 8'h02;

  // ****************************************
  // converter_bias_control fields
  // ****************************************
  localparam int BIAS_PD_BIT = 7;
  localparam int BIAS_MIRROR_BANDWIDTH_SELECT_HI = 1;
  localparam int BIAS_MIRROR_BANDWIDTH_SELECT_LO = 0;
  localparam logic [DATA_W-1:0] BIAS_MASK = 8'h83;
  localparam logic [DATA_W-1:0] BIAS_RST = 8'h00;

  // ****************************************
  // readback widths and pin synchroniser reset
  // ****************************************
  localparam int DELAY_W = 9;
  localparam int PHASE_W = 5;
  localparam logic [2:0] PIN_RST = 3'h4;

endpackage : dac_cfg_pkg

// >>> rtl/dac_clock_and_delay_ctrl_regs.sv
// module: clock receiver, delay-lock and bias configuration registers
// How it works
// - bit 7 enables sample-clock receiver
// - receiver enable resets to zero
// - bit 5 sets positive-pin level sign
// - bits 4:1 positive-pin level, default ones
// - bit 0 sets negative-pin level sign
// - bit 7 high stops delay controller clock
// - bit 6 target slope, compared when measured
// - bits 5:4 controller mode, 11 invalid
// - rising bit 3 captures locked delay/phase
// - bits 2:1 tracking gain, 11 invalid
// - bit 0 turns delay controller on
// - bias bit 7 powers converter down
// - bias bits 1:0 select mirror bandwidth
module dac_clock_and_delay_ctrl_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic clock_receiver_enable,
  output logic pos_pin_level_polarity,
  output logic [3:0] pos_pin_level_adjust,
  output logic neg_pin_level_polarity,
  output logic delay_ctrl_clock_gate,
  output logic target_slope_positive,
  output logic [1:0] delay_ctrl_mode,
  output logic [1:0] track_gain,
  output logic delay_ctrl_on,
  input wire logic [dac_cfg_pkg::DELAY_W-1:0] live_delay,
  input wire logic [dac_cfg_pkg::PHASE_W-1:0] live_phase,
  input wire logic measured_slope,
  input wire logic target_phase_hit,
  output logic slope_match,
  output logic lock_readback_capture,
  output logic [dac_cfg_pkg::DELAY_W-1:0] locked_delay_value,
  output logic [dac_cfg_pkg::PHASE_W-1:0] target_phase_value,
  output logic converter_power_down,
  output logic [1:0] mirror_bandwidth_select
);
  import dac_cfg_pkg::*;

  // ****************************************
  // serial port
  // ****************************************
  cfg_access_if acc ();

  cfg_serial_port u_port (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .sclk (sclk),
    .csb_n (csb_n),
    .sdio_i (sdio_i),
    .sdio_o (sdio_o),
    .sdio_oe (sdio_oe),
    .acc (acc)
  );

  // ****************************************
  // address decode
  // ****************************************
  logic hit_clkrx;
  logic hit_dly;
  logic hit_bias;
  logic wr_clkrx;
  logic wr_dly;
  logic wr_bias;

  assign hit_clkrx = (acc.addr == CLKRX_OFS);
  assign hit_dly = (acc.addr == DLYCTL_OFS);
  assign hit_bias = (acc.addr == BIAS_OFS);
  assign wr_clkrx = acc.wr_stb & hit_clkrx;
  assign wr_dly = acc.wr_stb & hit_dly;
  assign wr_bias = acc.wr_stb & hit_bias;

  // ****************************************
  // clock_receiver_control
  // ****************************************
  logic [DATA_W-1:0] clkrx_q;

  // reserved bit 6 is stored as written; the host keeps it at reset value
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkrx_q <= CLKRX_RST;
    end else if (wr_clkrx) begin
      clkrx_q <= acc.wdata;
    end
  end

  // enable stays off until the host has a stable clock
  assign clock_receiver_enable = clkrx_q[CLKRX_EN_BIT];
  assign pos_pin_level_polarity = clkrx_q[CLKRX_POS_PIN_LEVEL_POLARITY_BIT];
  assign pos_pin_level_adjust = clkrx_q[CLKRX_PADJ_HI:CLKRX_PADJ_LO];
  assign neg_pin_level_polarity = clkrx_q[CLKRX_NEG_PIN_LEVEL_POLARITY_BIT];

  // ****************************************
  // delay_lock_control
  // ****************************************
  logic [DATA_W-1:0] dly_q;
  logic [DATA_W-1:0] dly_d;
  logic [1:0] wr_mode;
  logic [1:0] wr_gain;
  logic [1:0] mode_d;
  logic [1:0] gain_d;
  logic capt_rise;

  assign wr_mode = acc.wdata[DLY_MODE_HI:DLY_MODE_LO];
  assign wr_gain = acc.wdata[DLY_GAIN_HI:DLY_GAIN_LO];
  // an invalid code keeps the field at its previous setting
  assign mode_d = (wr_mode == CODE_INVALID) ? dly_q[DLY_MODE_HI:DLY_MODE_LO] : wr_mode;
  assign gain_d = (wr_gain == CODE_INVALID) ? dly_q[DLY_GAIN_HI:DLY_GAIN_LO] : wr_gain;
  assign dly_d = {acc.wdata[DLY_GATE_BIT], acc.wdata[DLY_SLOPE_BIT], mode_d,
                  acc.wdata[DLY_CAPT_BIT], gain_d, acc.wdata[DLY_EN_BIT]};
  assign capt_rise = wr_dly & ~dly_q[DLY_CAPT_BIT] & acc.wdata[DLY_CAPT_BIT];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_q <= DLYCTL_RST;
    end else if (wr_dly) begin
      dly_q <= dly_d;
    end
  end

  assign delay_ctrl_clock_gate = dly_q[DLY_GATE_BIT];
  assign target_slope_positive = dly_q[DLY_SLOPE_BIT];
  assign delay_ctrl_mode = dly_q[DLY_MODE_HI:DLY_MODE_LO];
  assign track_gain = dly_q[DLY_GAIN_HI:DLY_GAIN_LO];
  // host turns on boost and duty correction before this bit
  assign delay_ctrl_on = dly_q[DLY_EN_BIT];

  // ****************************************
  // slope comparison and lock capture
  // ****************************************
  logic match_q;
  logic capt_q;
  logic [DELAY_W-1:0] cap_delay_q;
  logic [PHASE_W-1:0] cap_phase_q;

  // match is refreshed each time the target phase is seen
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_q <= 1'b0;
    end else if (target_phase_hit) begin
      match_q <= (measured_slope == dly_q[DLY_SLOPE_BIT]);
    end
  end

  // the controller keeps its delay at or below 431
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capt_q <= 1'b0;
      cap_delay_q <= 9'h000;
      cap_phase_q <= 5'h00;
    end else begin
      capt_q <= capt_rise;
      if (capt_rise) begin
        cap_delay_q <= live_delay;
        cap_phase_q <= live_phase;
      end
    end
  end

  // host best practice: positive slope with phase 14
  assign slope_match = match_q;
  assign lock_readback_capture = capt_q;
  assign locked_delay_value = cap_delay_q;
  assign target_phase_value = cap_phase_q;

  // ****************************************
  // converter_bias_control
  // ****************************************
  logic [DATA_W-1:0] bias_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bias_q <= BIAS_RST;
    end else if (wr_bias) begin
      bias_q <= acc.wdata & BIAS_MASK;
    end
  end

  assign converter_power_down = bias_q[BIAS_PD_BIT];
  assign mirror_bandwidth_select = bias_q[BIAS_MIRROR_BANDWIDTH_SELECT_HI:BIAS_MIRROR_BANDWIDTH_SELECT_LO];

  // ****************************************
  // read mux: unmapped offsets read zero
  // ****************************************
  assign acc.rdata = hit_clkrx ? clkrx_q :
                     hit_dly ? dly_q :
                     hit_bias ? bias_q : 8'h00;

endmodule : dac_clock_and_delay_ctrl_regs

// >>> verification/dac_cfg_checker.sv
// checker: port timing relations of the config register block
module dac_cfg_checker
  import dac_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic csb_n,
  input wire logic clock_receiver_enable,
  input wire logic target_slope_positive,
  input wire logic [1:0] delay_ctrl_mode,
  input wire logic [1:0] track_gain,
  input wire logic measured_slope,
  input wire logic target_phase_hit,
  input wire logic slope_match,
  input wire logic lock_readback_capture,
  input wire logic [dac_cfg_pkg::DELAY_W-1:0] live_delay,
  input wire logic [dac_cfg_pkg::DELAY_W-1:0] locked_delay_value,
  input wire logic converter_power_down
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // assertions
  // ****************************************
  sequence idle_frame;
    csb_n [*8];
  endsequence
  sequence capture_seen;
    $changed(locked_delay_value);
  endsequence
  a_mode_code_valid: assert property (delay_ctrl_mode != CODE_INVALID)
    else $error("mode code 11 on output");
  a_gain_code_valid: assert property (track_gain != CODE_INVALID)
    else $error("gain code 11 on output");
  a_slope_compare_update: assert property (target_phase_hit |=>
    slope_match == $past(measured_slope == target_slope_positive))
    else $error("slope match wrong after hit");
  a_slope_match_hold: assert property (!target_phase_hit |=> $stable(slope_match))
    else $error("slope match moved without hit");
  // the captured value and the pulse appear on the same edge
  a_capture_then_pulse: assert property (capture_seen |-> lock_readback_capture)
    else $error("capture without pulse");
  a_capture_pulse_single: assert property (lock_readback_capture |=> !lock_readback_capture)
    else $error("capture pulse too long");
  a_capture_value_live: assert property (lock_readback_capture |->
    locked_delay_value == $past(live_delay))
    else $error("captured delay differs from live");
  a_idle_regs_stable: assert property (idle_frame |=>
    $stable(clock_receiver_enable) && $stable(converter_power_down))
    else $error("register changed with no frame");
endmodule : dac_cfg_checker

bind dac_clock_and_delay_ctrl_regs dac_cfg_checker u_chk (.core_clk, .sys_rst, .csb_n,
  .clock_receiver_enable, .target_slope_positive, .delay_ctrl_mode, .track_gain,
  .measured_slope, .target_phase_hit, .slope_match, .lock_readback_capture, .live_delay,
  .locked_delay_value, .converter_power_down);

// >>> verification/tb_top.sv
// testbench: serial-port scenarios for the clock, delay-lock and bias registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dac_cfg_pkg::*;
  logic core_clk = 0, sys_rst = 1, sclk = 0, csb_n = 1, sdio_i = 0;
  logic measured_slope = 0, target_phase_hit = 0;
  logic [DELAY_W-1:0] live_delay = '0;
  logic [PHASE_W-1:0] live_phase = '0;
  logic sdio_o, sdio_oe, clock_receiver_enable, pos_pin_level_polarity, neg_pin_level_polarity;
  logic delay_ctrl_clock_gate, target_slope_positive, delay_ctrl_on, slope_match;
  logic lock_readback_capture, converter_power_down;
  logic [3:0] pos_pin_level_adjust;
  logic [1:0] delay_ctrl_mode, track_gain, mirror_bandwidth_select;
  logic [DELAY_W-1:0] locked_delay_value;
  logic [PHASE_W-1:0] target_phase_value;
  logic [7:0] q;
  logic oe;
  int errors = 0, num_checks = 0, cycles = 0, caps = 0;
  dac_clock_and_delay_ctrl_regs u_dut (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .sclk (sclk),
    .csb_n (csb_n),
    .sdio_i (sdio_i),
    .sdio_o (sdio_o),
    .sdio_oe (sdio_oe),
    .clock_receiver_enable (clock_receiver_enable),
    .pos_pin_level_polarity (pos_pin_level_polarity),
    .pos_pin_level_adjust (pos_pin_level_adjust),
    .neg_pin_level_polarity (neg_pin_level_polarity),
    .delay_ctrl_clock_gate (delay_ctrl_clock_gate),
    .target_slope_positive (target_slope_positive),
    .delay_ctrl_mode (delay_ctrl_mode),
    .track_gain (track_gain),
    .delay_ctrl_on (delay_ctrl_on),
    .live_delay (live_delay),
    .live_phase (live_phase),
    .measured_slope (measured_slope),
    .target_phase_hit (target_phase_hit),
    .slope_match (slope_match),
    .lock_readback_capture (lock_readback_capture),
    .locked_delay_value (locked_delay_value),
    .target_phase_value (target_phase_value),
    .converter_power_down (converter_power_down),
    .mirror_bandwidth_select (mirror_bandwidth_select)
  );
  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (lock_readback_capture === 1'b1) caps++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test();
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task xfer(logic [15:0] ins, logic [7:0] d);
    logic [23:0] f;
    f = {ins, d};
    @(posedge core_clk);
    csb_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdio_i <= f[i];
      repeat (8) @(posedge core_clk);
      if (i < 8) q[i] = sdio_o;
      if (i == 0) oe = sdio_oe;
      sclk <= 1'b1;
      repeat (8) @(posedge core_clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    csb_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : xfer
  task wr(logic [ADDR_W-1:0] a, logic [7:0] d);
    xfer({3'h0, a}, d);
  endtask : wr
  task rdchk(logic [ADDR_W-1:0] a, logic [7:0] e);
    xfer({3'h4, a}, 8'h00);
    chk("readback", q, e);
  endtask : rdchk
  task hit(logic m);
    measured_slope <= m;
    target_phase_hit <= 1'b1;
    @(posedge core_clk);
    target_phase_hit <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : hit
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset();
    chk("rx_en", clock_receiver_enable, 1'b0);
    chk("pos_adj", pos_pin_level_adjust, 4'hF);
    rdchk(CLKRX_OFS, CLKRX_RST);
    rdchk(BIAS_OFS, BIAS_RST);
    chk("rd_oe", oe, 1'b1);
    chk("idle_oe", sdio_oe, 1'b0);
  endtask : t_reset
  task t_clkrx();
    // sample clock is taken as stable once reset is over; bit 6 kept at 0
    wr(CLKRX_OFS, 8'hA1);
    chk("wr_oe", oe, 1'b0);
    chk("clkrx", {clock_receiver_enable, pos_pin_level_polarity, pos_pin_level_adjust,
      neg_pin_level_polarity}, 7'h61);
    wr(CLKRX_OFS, 8'h1C);
    chk("clkrx", {clock_receiver_enable, pos_pin_level_polarity, pos_pin_level_adjust,
      neg_pin_level_polarity}, 7'h1C);
    rdchk(CLKRX_OFS, 8'h1C);
  endtask : t_clkrx
  task t_delay();
    live_delay <= 9'h1AF;
    live_phase <= 5'h0E;
    caps = 0;
    // boost and duty correction live outside this block and count as on
    wr(DLYCTL_OFS, 8'hCB);
    chk("caps", caps, 1);
    chk("delay", locked_delay_value, 9'h1AF);
    chk("phase", target_phase_value, 5'h0E);
    chk("dly", {delay_ctrl_clock_gate, target_slope_positive, delay_ctrl_mode, track_gain,
      delay_ctrl_on}, 7'h63);
    live_delay <= 9'h0D8;
    wr(DLYCTL_OFS, 8'hCB);
    chk("caps", caps, 1);
    chk("delay", locked_delay_value, 9'h1AF);
    wr(DLYCTL_OFS, 8'hC3);
    wr(DLYCTL_OFS, 8'hCB);
    chk("caps", caps, 2);
    chk("delay", locked_delay_value, 9'h0D8);
  endtask : t_delay
  task t_modes();
    for (int k = 0; k < 3; k++) begin
      wr(DLYCTL_OFS, {2'h0, k[1:0], 1'b0, k[1:0], 1'b0});
      chk("mode_gain", {delay_ctrl_mode, track_gain}, {k[1:0], k[1:0]});
    end
    wr(DLYCTL_OFS, 8'hF6);
    chk("dly", {delay_ctrl_clock_gate, target_slope_positive, delay_ctrl_mode, track_gain,
      delay_ctrl_on}, 7'h74);
    rdchk(DLYCTL_OFS, 8'hE4);
  endtask : t_modes
  task t_slope();
    hit(1'b1);
    chk("slope", slope_match, 1'b1);
    hit(1'b0);
    chk("slope", slope_match, 1'b0);
    measured_slope <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("slope", slope_match, 1'b0);
  endtask : t_slope
  task t_bias();
    wr(BIAS_OFS, 8'hFF);
    chk("bias", {converter_power_down, mirror_bandwidth_select}, 3'h7);
    rdchk(BIAS_OFS, BIAS_MASK);
    for (int k = 0; k < 3; k++) begin
      wr(BIAS_OFS, {1'b0, 5'h1F, k[1:0]});
      chk("bias", {converter_power_down, mirror_bandwidth_select}, {1'b0, k[1:0]});
    end
  endtask : t_bias
  task t_unmapped();
    wr(13'h0034, 8'hFF);
    rdchk(13'h0034, 8'h00);
    rdchk(CLKRX_OFS, 8'h1C);
  endtask : t_unmapped
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_clkrx();
    t_delay();
    t_modes();
    t_slope();
    t_bias();
    t_unmapped();
    end_of_test();
  end
endmodule : tb_top
